// [rtl/dmar_params.svh]
// Constants of the data memory access router
`ifndef DMAR_PARAMS_SVH
`define DMAR_PARAMS_SVH
`define DMAR_CLKS_PER_MC      3'd4
`define DMAR_XRAM_LAST        16'h03FF
`define DMAR_STRETCH_MIN      4'd2
`define DMAR_STRETCH_MAX      4'd9
`define DMAR_PTR_DEC_OPCODE   8'hA5
`define DMAR_PTR_RESET        16'h0000
`define DMAR_SCRATCH_WORDS    256
`define DMAR_XRAM_WORDS       1024
`endif

// [rtl/dmar_pkg.sv]
// Types of the data memory access router
package dmar_pkg;
  typedef enum logic [1:0] {
    DMAR_PTR_NONE,
    DMAR_PTR_LOAD,
    DMAR_PTR_INC,
    DMAR_PTR_DEC
  } dmar_ptr_op_t;

  typedef enum logic [2:0] {
    DMAR_IDLE,
    DMAR_ADDR,
    DMAR_STROBE,
    DMAR_HOLD,
    DMAR_FINISH
  } dmar_state_t;

  // Request from the core
  typedef struct packed {
    logic        start;
    logic        write;
    logic        use_ri;
    logic [7:0]  ri_addr;
    logic [7:0]  wdata;
  } dmar_req_t;

  // External bus pin drive
  typedef struct packed {
    logic [7:0]  p0_out;
    logic [7:0]  p0_oe_n;
    logic [7:0]  p2_out;
    logic        ale;
    logic        wr_n;
    logic        rd_n;
  } dmar_pins_t;
endpackage

// [rtl/dmar_ram.sv]
// Single-port synchronous RAM used for scratchpad and move SRAM
`timescale 1ns/1ps
module dmar_ram #(
  parameter int WORDS = 1024,
  parameter int AW    = 10
) (
  input  wire logic          core_clk_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [WORDS];

  // Elaboration check: the address must reach every word
  if (WORDS > (1 << AW)) begin : g_bad_size
    $error("dmar_ram: WORDS exceeds address width");
  end

  // Read-first port; each instance owns its array so nothing aliases
  always_ff @(posedge core_clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule

// [rtl/dmar_top.sv]
// Data memory access router: pointers, on-chip SRAM and external bus
`timescale 1ns/1ps
`include "dmar_params.svh"
module dmar_top
  import dmar_pkg::*;
#(
  parameter int XRAM_WORDS = `DMAR_XRAM_WORDS
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Core side
  input  wire logic         onchip_xram_enable_i,
  input  wire logic         wait_enable_i,
  input  wire logic [3:0]   stretch_i,
  input  wire logic         ptr_sel_i,
  input  wire logic [7:0]   opcode_i,
  input  wire logic         opcode_valid_i,
  input  wire logic         ptr_load_i,
  input  wire logic [15:0]  ptr_load_val_i,
  input  wire logic         ptr_inc_i,
  input  wire dmar_req_t    req_i,
  input  wire logic         scr_we_i,
  input  wire logic [7:0]   scr_addr_i,
  input  wire logic [7:0]   scr_wdata_i,
  output logic      [7:0]   scr_rdata_o,
  output logic              busy_o,
  output logic              done_o,
  output logic      [7:0]   rdata_o,
  output logic      [15:0]  active_pointer_o,
  output logic      [15:0]  second_pointer_o,
  output logic              onchip_xram_enable_o,
  // External pins
  input  wire logic [7:0]   p0_i,
  output logic      [7:0]   p0_o,
  output logic      [7:0]   p0_oe_n_o,
  output logic      [7:0]   p2_o,
  output logic              ale_o,
  output logic              p3_6_wr_n_o,
  output logic              p3_7_rd_n_o,
  input  wire logic         wait_request_in_i,
  output logic              p4_0_oe_n_o
);
  // Elaboration check: the move SRAM decode is fixed at 1KB
  if (XRAM_WORDS != `DMAR_XRAM_WORDS) begin : g_bad_xram
    $error("dmar_top: on-chip SRAM size must be 1KB");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    dmar_state_t st;
    logic        xram_en;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [15:0] addr;
    logic        write;
    logic        internal;
    logic [7:0]  wdata;
    logic [1:0]  phase;
    logic [3:0]  mc_left;
    logic [7:0]  rdata;
    logic        done;
    logic [7:0]  p0_sync1;
    logic [7:0]  p0_sync2;
    logic        wait_sync1;
    logic        wait_sync2;
    dmar_pins_t  pins;
  } dmar_regs_t;

  dmar_regs_t r_r;
  dmar_regs_t r_nxt;
  logic [7:0] xram_rdata;
  logic       xram_we;
  logic       xram_ce;

  // Separate arrays: scratchpad writes can never reach the move SRAM
  dmar_ram #(.WORDS(`DMAR_SCRATCH_WORDS), .AW(8)) u_scratch (
    .core_clk_i (core_clk_i),
    .ce_i       (ce_i),
    .we_i       (scr_we_i),
    .addr_i     (scr_addr_i),
    .wdata_i    (scr_wdata_i),
    .rdata_o    (scr_rdata_o)
  );

  // Only the move path addresses this array; no fetch port exists
  dmar_ram #(.WORDS(`DMAR_XRAM_WORDS), .AW(10)) u_xram (
    .core_clk_i (core_clk_i),
    .ce_i       (xram_ce),
    .we_i       (xram_we),
    .addr_i     (r_r.addr[9:0]),
    .wdata_i    (r_r.wdata),
    .rdata_o    (xram_rdata)
  );

  assign xram_ce = ce_i && (r_r.st == DMAR_STROBE) && r_r.internal;
  assign xram_we = r_r.write;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [15:0] ptr;
    logic [15:0] eff;
    logic [3:0]  len;
    len = stretch_i;
    r_nxt = r_r;
    ptr = ptr_sel_i ? r_r.ptr1 : r_r.ptr0;
    eff = req_i.use_ri ? {r_r.pins.p2_out, req_i.ri_addr} : ptr;
    // Clamp the stretch setting into the legal range
    if (stretch_i < `DMAR_STRETCH_MIN) begin
      len = `DMAR_STRETCH_MIN;
    end else if (stretch_i > `DMAR_STRETCH_MAX) begin
      len = `DMAR_STRETCH_MAX;
    end else begin
      len = stretch_i;
    end
    r_nxt.done = 1'b0;
    r_nxt.xram_en = onchip_xram_enable_i;
    // Pin synchronisers
    r_nxt.p0_sync1 = p0_i;
    r_nxt.p0_sync2 = r_r.p0_sync1;
    r_nxt.wait_sync1 = wait_request_in_i;
    r_nxt.wait_sync2 = r_r.wait_sync1;
    // Pointer updates act on the selected pointer only
    if (ptr_load_i) begin
      if (ptr_sel_i) r_nxt.ptr1 = ptr_load_val_i;
      else r_nxt.ptr0 = ptr_load_val_i;
    end else if (opcode_valid_i && opcode_i == `DMAR_PTR_DEC_OPCODE) begin
      if (ptr_sel_i) r_nxt.ptr1 = r_r.ptr1 - 16'h0001;
      else r_nxt.ptr0 = r_r.ptr0 - 16'h0001;
    end else if (ptr_inc_i) begin
      if (ptr_sel_i) r_nxt.ptr1 = r_r.ptr1 + 16'h0001;
      else r_nxt.ptr0 = r_r.ptr0 + 16'h0001;
    end
    // Machine-cycle phase counter
    r_nxt.phase = r_r.phase + 2'd1;
    unique case (r_r.st)
      DMAR_IDLE: begin
        r_nxt.phase = 2'd0;
        r_nxt.pins.ale = 1'b0;
        if (req_i.start) begin
          r_nxt.addr = eff;
          r_nxt.write = req_i.write;
          r_nxt.wdata = req_i.wdata;
          r_nxt.mc_left = len - 4'd1;
          r_nxt.internal = r_r.xram_en && (eff <= `DMAR_XRAM_LAST);
          if (r_r.xram_en && (eff <= `DMAR_XRAM_LAST)) begin
            r_nxt.st = DMAR_STROBE;
          end else begin
            // Drive address on both ports; latch strobe high
            r_nxt.st = DMAR_ADDR;
            r_nxt.pins.p0_out = eff[7:0];
            r_nxt.pins.p0_oe_n = 8'h00;
            r_nxt.pins.p2_out = eff[15:8];
            r_nxt.pins.ale = 1'b1;
          end
        end
      end
      DMAR_ADDR: begin
        // Latch strobe falls mid-cycle while address is still stable
        if (r_r.phase == 2'd1) r_nxt.pins.ale = 1'b0;
        if (r_r.phase == `DMAR_CLKS_PER_MC - 3'd1) begin
          r_nxt.st = DMAR_STROBE;
          if (r_r.write) begin
            r_nxt.pins.p0_out = r_r.wdata;
            r_nxt.pins.wr_n = 1'b0;
          end else begin
            r_nxt.pins.p0_oe_n = 8'hFF;
            r_nxt.pins.rd_n = 1'b0;
          end
        end
      end
      DMAR_STROBE: begin
        if (r_r.phase == `DMAR_CLKS_PER_MC - 3'd1) begin
          if (r_r.mc_left > 4'd1) begin
            r_nxt.mc_left = r_r.mc_left - 4'd1;
          end else if (!r_r.internal && wait_enable_i && r_r.wait_sync2) begin
            r_nxt.st = DMAR_HOLD;
          end else begin
            r_nxt.st = DMAR_FINISH;
            // Sample read data while the read strobe is still low
            r_nxt.rdata = r_r.internal ? xram_rdata : r_r.p0_sync2;
          end
        end
      end
      DMAR_HOLD: begin
        // Strobe stays asserted until the wait request drops or wait_enable_i goes low
        if (!r_r.wait_sync2 || !wait_enable_i) begin
          r_nxt.st = DMAR_FINISH;
          r_nxt.rdata = r_r.p0_sync2;
        end
      end
      DMAR_FINISH: begin
        r_nxt.pins.wr_n = 1'b1;
        r_nxt.pins.rd_n = 1'b1;
        r_nxt.pins.p0_oe_n = 8'hFF;
        r_nxt.done = 1'b1;
        r_nxt.st = DMAR_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_r <= '0;
      r_r.st <= DMAR_IDLE;
      r_r.xram_en <= 1'b0;
      r_r.ptr0 <= `DMAR_PTR_RESET;
      r_r.ptr1 <= `DMAR_PTR_RESET;
      r_r.pins.p0_oe_n <= 8'hFF;
      r_r.pins.wr_n <= 1'b1;
      r_r.pins.rd_n <= 1'b1;
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign busy_o = (r_r.st != DMAR_IDLE);
  assign done_o = r_r.done;
  assign rdata_o = r_r.rdata;
  assign active_pointer_o = ptr_sel_i ? r_r.ptr1 : r_r.ptr0;
  assign second_pointer_o = r_r.ptr1;
  assign onchip_xram_enable_o = r_r.xram_en;
  assign p0_o = r_r.pins.p0_out;
  assign p0_oe_n_o = r_r.pins.p0_oe_n;
  assign p2_o = r_r.pins.p2_out;
  assign ale_o = r_r.pins.ale;
  assign p3_6_wr_n_o = r_r.pins.wr_n;
  assign p3_7_rd_n_o = r_r.pins.rd_n;
  // Wait pin is never driven by this block
  assign p4_0_oe_n_o = 1'b1;
endmodule

// [sim/dmar_top_sva.sv]
// Checker: pin, pointer and routing relations of the access router
`timescale 1ns/1ps
module dmar_top_sva
  import dmar_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire dmar_req_t   req_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        onchip_xram_enable_o,
  input wire logic [15:0] active_pointer_o,
  input wire logic [7:0]  opcode_i,
  input wire logic        opcode_valid_i,
  input wire logic        ptr_load_i,
  input wire logic        ptr_sel_i,
  input wire logic [7:0]  p0_oe_n_o,
  input wire logic        ale_o,
  input wire logic        p3_6_wr_n_o,
  input wire logic        p3_7_rd_n_o,
  input wire logic        p4_0_oe_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // An access is taken only from idle with the clock enabled
  logic take;
  assign take = req_i.start && !busy_o && ce_i;
  ////////////////////////////////////////////////////////////////////////
  AST_WAIT_PIN: assert property (p4_0_oe_n_o)
    else $error("wait pin driven");
  AST_RST_OFF: assert property ($fell(rst_i) |-> !onchip_xram_enable_o)
    else $error("on-chip enable set after reset");
  AST_ONE_STB: assert property (p3_6_wr_n_o || p3_7_rd_n_o)
    else $error("both strobes low");
  AST_WR_DRV: assert property (!p3_6_wr_n_o |-> p0_oe_n_o == 8'h00)
    else $error("port 0 not driven under write");
  AST_RD_REL: assert property (!p3_7_rd_n_o |-> p0_oe_n_o == 8'hFF)
    else $error("port 0 driven under read");
  AST_ALE: assert property ($rose(ale_o) |-> p0_oe_n_o == 8'h00
    ##1 ale_o ##1 (!ale_o && p3_6_wr_n_o && p3_7_rd_n_o))
    else $error("latch strobe wrong");
  AST_RD_DONE: assert property ($rose(p3_7_rd_n_o) |-> ##[0:4] done_o)
    else $error("read not completed after strobe");
  AST_ONCHIP: assert property (take && onchip_xram_enable_o
    && !req_i.use_ri && active_pointer_o <= 16'h03FF
    |=> (!ale_o && p3_7_rd_n_o && p3_6_wr_n_o) [*8])
    else $error("on-chip access reached the bus");
  AST_OFFCHIP: assert property (take && !onchip_xram_enable_o
    |-> ##[1:4] ale_o)
    else $error("external access without latch strobe");
  AST_DEC: assert property (opcode_valid_i && opcode_i == 8'hA5
    && !ptr_load_i && ce_i |=> ($stable(ptr_sel_i) ->
    active_pointer_o == $past(active_pointer_o) - 16'h0001))
    else $error("pointer decrement wrong");
endmodule

// [sim/dmar_xmem_model.sv]
// Behavioural external byte memory with address latch and wait request
`timescale 1ns/1ps
module dmar_xmem_model (
  input  wire logic        clk_i,
  input  wire logic        ale_i,
  input  wire logic [7:0]  ad_i,
  input  wire logic [7:0]  ad_oe_n_i,
  input  wire logic [7:0]  hi_i,
  input  wire logic        wr_n_i,
  input  wire logic        rd_n_i,
  input  int               wait_len_i,
  output logic      [7:0]  ad_o,
  output logic             wait_o
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic [7:0]  pat = 8'h5A;
  int          cnt = 0;
  // Latch is transparent while the strobe is high, holds once it drops
  always @(posedge clk_i) begin
    if (ale_i) addr <= {hi_i, ad_i};
    if (!wr_n_i) mem[addr] <= ad_i;
    pat <= ~pat;
    cnt <= (wr_n_i && rd_n_i) ? 0 : cnt + 1;
  end
  // A released bus floats, so it shows a changing pattern, not old data
  assign ad_o = !rd_n_i ? mem[addr] :
                (ad_oe_n_i == 8'h00 ? ad_i : pat);
  // Slow device: hold the access for a set count from the strobe edge
  assign wait_o = !(wr_n_i && rd_n_i) && cnt < wait_len_i;
endmodule

// [sim/dmar_top_bench.sv]
// Testbench: pointer, on-chip and external move accesses of the router
`timescale 1ns/1ps
module dmar_top_bench;
  import dmar_pkg::*;
  logic core_clk_i, rst_i, oxe, wen, sel, opv, ld, inc, swe, ce;
  logic [8:0] ri;
  logic [3:0] str;
  logic [7:0] opc, sa, sd, srd, rd, p0, p0_oe_n, p2, p0_in;
  logic [15:0] lv, ap, sp;
  dmar_req_t req;
  logic busy, done, oxe_o, ale, wr_n, rd_n, wreq, p4_oe_n;
  int fails, n_tests, wlen, lat, prev;
  dmar_top u_dmar_top (.core_clk_i, .rst_i, .ce_i(ce),
    .onchip_xram_enable_i(oxe), .wait_enable_i(wen), .stretch_i(str),
    .ptr_sel_i(sel), .opcode_i(opc), .opcode_valid_i(opv),
    .ptr_load_i(ld), .ptr_load_val_i(lv), .ptr_inc_i(inc), .req_i(req),
    .scr_we_i(swe), .scr_addr_i(sa), .scr_wdata_i(sd), .scr_rdata_o(srd),
    .busy_o(busy), .done_o(done), .rdata_o(rd), .active_pointer_o(ap),
    .second_pointer_o(sp), .onchip_xram_enable_o(oxe_o), .p0_i(p0_in),
    .p0_o(p0), .p0_oe_n_o(p0_oe_n), .p2_o(p2), .ale_o(ale),
    .p3_6_wr_n_o(wr_n), .p3_7_rd_n_o(rd_n), .wait_request_in_i(wreq),
    .p4_0_oe_n_o(p4_oe_n));
  dmar_xmem_model u_dmar_xmem_model (.clk_i(core_clk_i), .ale_i(ale),
    .ad_i(p0), .ad_oe_n_i(p0_oe_n), .hi_i(p2), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .wait_len_i(wlen), .ad_o(p0_in), .wait_o(wreq));
  ////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic step();
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One move access; lat counts edges from the take edge to done
  task automatic move(input logic w, input logic [7:0] d);
    req <= '{1'b1, w, ri[8], ri[7:0], d};
    step();
    chk(busy, 16'h0001);
    req.start <= 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < 600) begin
      step();
      lat++;
    end
    chk(done, 16'h0001);
    step();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, oxe, wen, sel, opv, ld, inc, swe} = 8'h80;
    {ce, str, opc} = {1'b1, 4'h2, 8'hA5};
    {sa, sd, lv} = 32'h0000_0000;
    req = '0;
    ri = 9'h000;
    {wlen, fails, n_tests} = '0;
    repeat (5) step();
    rst_i <= 1'b0;
    step();
    chk(oxe_o, 16'h0000);
    chk(p4_oe_n, 16'h0001);
    chk(ap, 16'h0000);
    // Load both pointers, then decrement the second across 1KB
    {ld, lv} <= {1'b1, 16'h1234};
    step();
    {sel, lv} <= {1'b1, 16'h0400};
    step();
    {ld, opv} <= 2'b01;
    step();
    opv <= 1'b0;
    step();
    chk(sp, 16'h03FF);
    chk(ap, 16'h03FF);
    // A low clock enable swallows the increment
    {ce, inc} <= 2'b01;
    step();
    {ce, inc} <= 2'b10;
    step();
    chk(ap, 16'h03FF);
    // The unselected pointer kept its value through the decrement
    sel <= 1'b0;
    step();
    chk(ap, 16'h1234);
    sel <= 1'b1;
    // External write and read at 03FF while the on-chip SRAM is off
    move(1'b1, 8'h3C);
    chk(u_dmar_xmem_model.mem[16'h03FF], 16'h003C);
    chk(u_dmar_xmem_model.addr, 16'h03FF);
    u_dmar_xmem_model.mem[16'h03FF] = 8'hC3;
    move(1'b0, 8'h00);
    chk(rd, 16'h00C3);
    // On-chip SRAM takes 03FF; the external byte stays as it was
    oxe <= 1'b1;
    step();
    step();
    move(1'b1, 8'h5A);
    chk(u_dmar_xmem_model.mem[16'h03FF], 16'h00C3);
    {swe, sa, sd} <= {1'b1, 8'hFF, 8'h11};
    step();
    swe <= 1'b0;
    step();
    chk(srd, 16'h0011);
    move(1'b0, 8'h00);
    chk(rd, 16'h005A);
    // One past the on-chip range goes to the bus again
    inc <= 1'b1;
    step();
    inc <= 1'b0;
    move(1'b1, 8'h77);
    chk(u_dmar_xmem_model.mem[16'h0400], 16'h0077);
    // A slow device stretches the read beyond its programmed length
    wen <= 1'b1;
    move(1'b0, 8'h00);
    prev = lat;
    wlen = 20;
    move(1'b0, 8'h00);
    chk(16'(lat >= prev + 10), 16'h0001);
    chk(rd, 16'h0077);
    {wen, wlen} = {1'b0, 32'd0};
    // Each further machine cycle of stretch adds four clocks
    for (int n = 2; n <= 9; n++) begin
      str <= n[3:0];
      step();
      move(1'b0, 8'h00);
      if (n > 2) chk(16'(lat - prev), 16'h0004);
      prev = lat;
    end
    // Indirect move: port 2 still holds 04 from the last bus access
    ri = {1'b1, 8'h10};
    move(1'b1, 8'h99);
    chk(u_dmar_xmem_model.mem[16'h0410], 16'h0099);
    tally_and_finish();
  end
endmodule
bind dmar_top dmar_top_sva u_dmar_top_sva (.core_clk_i, .rst_i, .ce_i,
  .req_i, .busy_o, .done_o, .onchip_xram_enable_o, .active_pointer_o,
  .opcode_i, .opcode_valid_i, .ptr_load_i, .ptr_sel_i, .p0_oe_n_o,
  .ale_o, .p3_6_wr_n_o, .p3_7_rd_n_o, .p4_0_oe_n_o);
